// >>> rtl/ter_pkg.sv
/*
  Constants, register map and bus states for the timer event request block.
  Assumes a 32-bit classic Wishbone bus with byte addresses and one clock.
*/
package ter_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] TER_IDX_MODE = 6'h00;
  localparam logic [5:0] TER_IDX_EXT  = 6'h02;
  localparam logic [5:0] TER_IDX_EVT  = 6'h03;
  localparam logic [5:0] TER_IDX_REF  = 6'h04;
  localparam logic [5:0] TER_IDX_CAP  = 6'h08;
  localparam logic [5:0] TER_IDX_CNT  = 6'h0C;
  localparam logic [5:0] TER_IDX_MASK = 6'h10;

  // Field positions
  localparam int TER_MODE_RUN_BIT   = 0;
  localparam int TER_MODE_MRE_BIT   = 4;
  localparam int TER_MODE_EDGE_LSB  = 6;
  localparam int TER_EXT_MIRROR_BIT = 0;
  localparam int TER_EXT_TRE_BIT    = 7;
  localparam int TER_EVT_EDGE_BIT   = 0;
  localparam int TER_EVT_MATCH_BIT  = 1;

  // Reset values
  localparam logic [7:0]  TER_MODE_RST = 8'h00;
  localparam logic [7:0]  TER_EXT_RST  = 8'h00;
  localparam logic [1:0]  TER_EVT_RST  = 2'h0;
  localparam logic [1:0]  TER_MASK_RST = 2'h3;
  localparam logic [31:0] TER_REF_RST  = 32'hFFFF_FFFF;
  localparam logic [31:0] TER_CAP_RST  = 32'h0000_0000;
  localparam logic [31:0] TER_CNT_RST  = 32'h0000_0000;

  // Counter steps
  localparam logic [31:0] TER_INC_SINGLE = 32'h0000_0001;
  localparam logic [31:0] TER_INC_MIRROR = 32'h0001_0001;

  // Edge select codes
  localparam logic [1:0] TER_EDGE_OFF  = 2'h0;
  localparam logic [1:0] TER_EDGE_RISE = 2'h1;
  localparam logic [1:0] TER_EDGE_FALL = 2'h2;
  localparam logic [1:0] TER_EDGE_ANY  = 2'h3;

  // Bus slave states
  typedef enum logic [1:0] {
    TER_BUS_IDLE = 2'b01,
    TER_BUS_ACK  = 2'b10
  } ter_bus_state_t;

endpackage

// >>> rtl/ter_edge_detect.sv
/*
  Synchroniser and selectable edge detector for the capture pin.
  Assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/10ps
module ter_edge_detect (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pin and selection
  input  wire logic       pin_i,
  input  wire logic [1:0] edge_sel_i,
  // Detected edge
  output logic            event_o
);
  import ter_pkg::*;

  logic sync1_ff;
  logic sync2_ff;
  logic last_ff;
  wire  rise_w;
  wire  fall_w;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser, then a history flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      last_ff  <= 1'b0;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
      last_ff  <= sync2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge selection
  assign rise_w  = sync2_ff & ~last_ff;
  assign fall_w  = ~sync2_ff & last_ff;
  assign event_o = ((edge_sel_i == TER_EDGE_RISE) & rise_w)
                 | ((edge_sel_i == TER_EDGE_FALL) & fall_w)
                 | ((edge_sel_i == TER_EDGE_ANY) & (rise_w | fall_w));

endmodule // ter_edge_detect

// >>> rtl/ter_event_request.sv
/*
  One timer channel: counter, reference match, input capture, event flags
  and routing of the flags to an interrupt or a transfer request.
  Assumes a classic Wishbone master on clk_i, a transfer controller whose
  acknowledge is synchronous to clk_i, and an asynchronous capture pin.
*/
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/10ps
module ter_event_request (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  // Capture pin
  input  wire logic        capture_pin_i,
  // Transfer controller
  input  wire logic        dma_ack_i,
  output logic             dma_req_o,
  // Interrupt controller
  output logic             irq_o
);
  import ter_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  ter_bus_state_t state_ff;
  ter_bus_state_t nxt_state;
  logic [31:0]    dat_ff;
  logic [7:0]     mode_ff;
  logic [7:0]     ext_ff;
  logic [1:0]     evt_ff;
  logic [1:0]     nxt_evt;
  logic [1:0]     mask_ff;
  logic [31:0]    ref_ff;
  logic [31:0]    cap_ff;
  logic [31:0]    cnt_ff;
  logic [31:0]    nxt_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire [5:0] idx_w      = wb_adr_i[7:2];
  wire       req_w      = wb_cyc_i & wb_stb_i;
  wire       fire_w     = wb_ack_o & req_w;
  wire       wr_w       = fire_w & wb_we_i;
  wire       hit_mode_w = (idx_w == TER_IDX_MODE);
  wire       hit_ext_w  = (idx_w == TER_IDX_EXT);
  wire       hit_evt_w  = (idx_w == TER_IDX_EVT);
  wire       hit_ref_w  = (idx_w == TER_IDX_REF);
  wire       hit_cap_w  = (idx_w == TER_IDX_CAP);
  wire       hit_cnt_w  = (idx_w == TER_IDX_CNT);
  wire       hit_mask_w = (idx_w == TER_IDX_MASK);
  wire       wr_lane0_w = wr_w & wb_sel_i[0];
  wire       wr_mode_w  = wr_lane0_w & hit_mode_w;
  wire       wr_ext_w   = wr_lane0_w & hit_ext_w;
  wire       wr_evt_w   = wr_lane0_w & hit_evt_w;
  wire       wr_mask_w  = wr_lane0_w & hit_mask_w;
  wire       wr_cnt_w   = wr_w & hit_cnt_w & (|wb_sel_i);

  ////////////////////////////////////////////////////////////////////////////
  // Control fields
  wire       run_w      = mode_ff[TER_MODE_RUN_BIT];
  wire       mre_w      = mode_ff[TER_MODE_MRE_BIT];
  wire [1:0] edge_sel_w = mode_ff[TER_MODE_EDGE_LSB +: 2];
  wire       mirror_w   = ext_ff[TER_EXT_MIRROR_BIT];
  wire       tre_w      = ext_ff[TER_EXT_TRE_BIT];
  wire       edge_en_w  = (edge_sel_w != TER_EDGE_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // Capture edge detection
  logic cap_evt_w;

  ter_edge_detect u_edge (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pin_i      (capture_pin_i),
    .edge_sel_i (edge_sel_w),
    .event_o    (cap_evt_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter and full-width reference match
  wire [31:0] step_w  = mirror_w ? TER_INC_MIRROR : TER_INC_SINGLE;
  wire        match_w = run_w & (cnt_ff == ref_ff);

  // Write clears, otherwise step while running
  always_comb begin
    nxt_cnt = cnt_ff;
    if (wr_cnt_w) begin
      nxt_cnt = TER_CNT_RST;
    end else if (run_w) begin
      nxt_cnt = cnt_ff + step_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags: set wins over every clear
  wire [1:0] set_w   = {match_w, cap_evt_w};
  wire [1:0] w1c_w   = wr_evt_w ? wb_dat_i[1:0] : 2'h0;
  wire [1:0] ackcl_w = dma_ack_i ? 2'h3 : 2'h0;

  always_comb begin
    nxt_evt = (evt_ff & ~(w1c_w | ackcl_w)) | set_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request routing
  wire match_req_w = evt_ff[TER_EVT_MATCH_BIT] & mre_w;
  wire edge_req_w  = evt_ff[TER_EVT_EDGE_BIT] & edge_en_w;
  wire [1:0] irq_src_w = {match_req_w, edge_req_w} & {2{~tre_w}};

  assign dma_req_o = tre_w & (match_req_w | edge_req_w);
  assign irq_o     = |(irq_src_w & mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped bits and reserved bits outside mode read zero; mode reads back all eight stored bits
  logic [31:0] rd_w;

  always_comb begin
    rd_w = 32'h0000_0000;
    case (1'b1)
      hit_mode_w: rd_w[7:0] = mode_ff;
      hit_ext_w:  rd_w[7:0] = ext_ff;
      hit_evt_w:  rd_w[1:0] = evt_ff;
      hit_ref_w:  rd_w      = ref_ff;
      hit_cap_w:  rd_w      = cap_ff;
      hit_cnt_w:  rd_w      = cnt_ff;
      hit_mask_w: rd_w[1:0] = mask_ff;
      default:    rd_w      = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: ack one cycle after the request, for one cycle
  always_comb begin
    case (state_ff)
      TER_BUS_IDLE: nxt_state = req_w ? TER_BUS_ACK : TER_BUS_IDLE;
      TER_BUS_ACK:  nxt_state = TER_BUS_IDLE;
      default:      nxt_state = TER_BUS_IDLE;
    endcase
  end

  assign wb_ack_o = (state_ff == TER_BUS_ACK);
  assign wb_dat_o = dat_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= TER_BUS_IDLE;
      dat_ff   <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      dat_ff   <= rd_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Narrow control registers; reserved ext bits never stored, mode stores all eight bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ff <= TER_MODE_RST;
      ext_ff  <= TER_EXT_RST;
      mask_ff <= TER_MASK_RST;
      evt_ff  <= TER_EVT_RST;
    end else begin
      if (wr_mode_w) begin
        mode_ff <= wb_dat_i[7:0];
      end
      if (wr_ext_w) begin
        ext_ff <= wb_dat_i[7:0] & 8'h81;
      end
      if (wr_mask_w) begin
        mask_ff <= wb_dat_i[1:0];
      end
      evt_ff <= nxt_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= TER_CNT_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference and capture, one byte lane each
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      wire wr_ref_b = wr_w & hit_ref_w & wb_sel_i[lane];
      wire wr_cap_b = wr_w & hit_cap_w & wb_sel_i[lane];

      // Reference byte
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ref_ff[lane*8 +: 8] <= TER_REF_RST[lane*8 +: 8];
        end else if (wr_ref_b) begin
          ref_ff[lane*8 +: 8] <= wb_dat_i[lane*8 +: 8];
        end
      end

      // Capture byte; a live edge beats a software write
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cap_ff[lane*8 +: 8] <= TER_CAP_RST[lane*8 +: 8];
        end else if (cap_evt_w) begin
          cap_ff[lane*8 +: 8] <= cnt_ff[lane*8 +: 8];
        end else if (wr_cap_b) begin
          cap_ff[lane*8 +: 8] <= wb_dat_i[lane*8 +: 8];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_bus_req;
    req_w && (state_ff == TER_BUS_IDLE);
  endsequence

  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_bus_ack_timing: assert property (s_bus_req |=> s_ack_once)
    else $error("bus ack not one cycle after request");

  a_single_step: assert property (
    (run_w && !mirror_w && !wr_cnt_w) |=> (cnt_ff == $past(cnt_ff) + TER_INC_SINGLE))
    else $error("counter did not step by one");

  a_mirror_step: assert property (
    (run_w && mirror_w && !wr_cnt_w) |=> (cnt_ff == $past(cnt_ff) + TER_INC_MIRROR))
    else $error("counter did not step by 65537");

  a_half_match_none: assert property (
    (evt_ff[1] == 1'b0) && (cnt_ff[15:0] == ref_ff[15:0])
    && (cnt_ff[31:16] != ref_ff[31:16]) |=> (evt_ff[1] == 1'b0))
    else $error("match flag set on a half-width compare");

  a_match_sets: assert property (
    (run_w && (cnt_ff == ref_ff)) |=> evt_ff[1])
    else $error("match flag not set on equal count");

  a_edge_sets: assert property (
    cap_evt_w |=> evt_ff[0])
    else $error("edge flag not set on capture event");

  a_w1c_both: assert property (
    (wr_evt_w && (wb_dat_i[1:0] == 2'h3) && !match_w && !cap_evt_w) |=> (evt_ff == 2'h0))
    else $error("write of ones did not clear both flags");

  a_w1c_zero_keeps: assert property (
    (wr_evt_w && (wb_dat_i[1:0] == 2'h0) && !dma_ack_i && !match_w && !cap_evt_w)
    |=> (evt_ff == $past(evt_ff)))
    else $error("write of zeros changed a flag");

  a_ack_clears: assert property (
    (dma_ack_i && !match_w && !cap_evt_w) |=> (evt_ff == 2'h0))
    else $error("transfer acknowledge did not clear flags");

  a_route_dma: assert property (
    tre_w |-> (!irq_o && (dma_req_o == (match_req_w || edge_req_w))))
    else $error("request not routed to transfer");

  a_edge_off_quiet: assert property (
    (edge_sel_w == 2'h0) && !(evt_ff[1] && mre_w) |-> (!irq_o && !dma_req_o))
    else $error("request raised with edge select off");

  a_irq_release: assert property (
    (evt_ff == 2'h0) |-> (!irq_o && !dma_req_o))
    else $error("request stands with no flag set");

  a_match_gate: assert property (
    (!mre_w && !evt_ff[0]) |-> (!irq_o && !dma_req_o))
    else $error("match request without enable");

  a_evt_readback: assert property (
    (s_bus_req ##0 (hit_evt_w && !wb_we_i)) |=> (wb_dat_o[31:2] == 30'h0))
    else $error("event register upper bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Further checks on bus, counter, capture and routing

  // Capture event, then the count lands in the capture register
  sequence s_edge_seen;
    cap_evt_w;
  endsequence

  sequence s_count_latched;
    cap_ff == $past(cnt_ff);
  endsequence

  a_capture_latch: assert property (s_edge_seen |=> s_count_latched)
    else $error("capture register missed the count");

  a_ack_after_req: assert property (wb_ack_o |-> $past(req_w))
    else $error("bus ack without a request");

  // Counter holds, clears and mirrors; flags hold; no capture event with edge select off
  a_count_hold: assert property (
    (!run_w && !wr_cnt_w) |=> (cnt_ff == $past(cnt_ff)))
    else $error("counter moved while stopped");

  a_count_clear: assert property (
    wr_cnt_w |=> (cnt_ff == TER_CNT_RST))
    else $error("counter write did not clear the count");

  a_mirror_halves: assert property (
    (run_w && mirror_w && !wr_cnt_w && (cnt_ff[31:16] == cnt_ff[15:0])
     && (cnt_ff[15:0] != 16'hFFFF)) |=> (cnt_ff[31:16] == cnt_ff[15:0]))
    else $error("upper half stopped mirroring lower half");

  a_flags_hold: assert property (
    (!wr_evt_w && !dma_ack_i && !match_w && !cap_evt_w) |=> (evt_ff == $past(evt_ff)))
    else $error("event flags changed with no cause");

  a_edge_off_none: assert property (
    (edge_sel_w == TER_EDGE_OFF) |-> !cap_evt_w)
    else $error("capture event with edge select off");

  // Requests follow flags and enables
  a_match_irq: assert property (
    (!tre_w && evt_ff[TER_EVT_MATCH_BIT] && mre_w && mask_ff[1]) |-> irq_o)
    else $error("match interrupt missing");

  a_edge_irq: assert property (
    (!tre_w && evt_ff[TER_EVT_EDGE_BIT] && edge_en_w && mask_ff[0]) |-> irq_o)
    else $error("edge interrupt missing");

  a_flag_dma: assert property (
    (tre_w && ((evt_ff[1] && mre_w) || (evt_ff[0] && edge_en_w))) |-> dma_req_o)
    else $error("transfer request missing");

endmodule // ter_event_request

// >>> test/ter_xfer_model.sv
/*
  Transfer controller model facing the timer request output.
  Assumes a level request on the bench clock; answers after lat_i cycles.
*/
`timescale 1ns/10ps
module ter_xfer_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench control
  input  wire logic       ack_en_i,
  input  wire logic [2:0] lat_i,
  // Request and acknowledge
  input  wire logic       dma_req_i,
  output logic            dma_ack_o
);
  logic [2:0] wait_ff;
  ////////////////////////////////////////////////////////////////
  // One acknowledge pulse once the request has waited lat_i cycles
  always_ff @(posedge clk_i) begin
    if (rst_i || !dma_req_i || !ack_en_i || dma_ack_o) begin
      wait_ff   <= 3'h0;
      dma_ack_o <= 1'b0;
    end else if (wait_ff == lat_i) begin
      dma_ack_o <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 3'h1;
    end
  end
endmodule // ter_xfer_model

// >>> test/tb.sv
/*
  Self-checking bench for the timer event request block.
  Assumes the design package and a transfer controller model.
*/
`timescale 1ns/10ps
module tb;
  import ter_pkg::*;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic [7:0]  wb_adr  = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_we   = 1'b0;
  logic [3:0]  wb_sel  = 4'h0;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_ack;
  logic        pin     = 1'b0;
  logic        dma_ack;
  logic        dma_req;
  logic        irq;
  logic        ack_en  = 1'b0;
  logic [2:0]  lat     = 3'h0;
  logic [31:0] rd;
  logic [31:0] c1;
  int          err_total   = 0;
  int          check_count = 0;
  int          cyc_cnt     = 0;
  int          d;
  ter_event_request dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_ack_o(wb_ack), .capture_pin_i(pin),
    .dma_ack_i(dma_ack), .dma_req_o(dma_req), .irq_o(irq));
  ter_xfer_model partner (
    .clk_i(clk_i), .rst_i(rst_i), .ack_en_i(ack_en), .lat_i(lat),
    .dma_req_i(dma_req), .dma_ack_o(dma_ack));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Checking, bus and expectation helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
    @(posedge clk_i);
    chk("ack drop", {31'h0, wb_ack}, 32'h0);
    wb_adr  <= a;
    wb_we   <= w;
    wb_wdat <= v;
    wb_sel  <= 4'hF;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(a, 1'b1, v);
  endtask
  task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] v);
    bus(a, 1'b0, 32'h0);
    chk(nm, rd, v);
  endtask
  task automatic run_match(input logic [31:0] rv, input logic [7:0] base);
    wr(8'h30, 32'h0);
    wr(8'h10, rv);
    wr(8'h00, {24'h0, base | 8'h01});
    repeat (12) @(posedge clk_i);
    wr(8'h00, {24'h0, base});
  endtask
  function automatic logic [1:0] route(input logic [1:0] fl, input logic [1:0] es,
                                       input logic mre, input logic tre, input logic [1:0] m);
    logic mt;
    logic ed;
    mt = fl[1] & mre;
    ed = fl[0] & (es != TER_EDGE_OFF);
    return {tre & (mt | ed), ~tre & ((mt & m[1]) | (ed & m[0]))};
  endfunction
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    d = $urandom(32'h77565327);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h08, "ext reset", 32'h0);
    rdc(8'h0C, "evt reset", 32'h0);
    rdc(8'h10, "ref reset", TER_REF_RST);
    rdc(8'h3C, "unmapped", 32'h0);
    wr(8'h08, 32'h81);
    rdc(8'h08, "ext rw", 32'h81);
    $display("registers test done");
    d = $urandom_range(20, 1);
    for (int m = 0; m < 2; m++) begin
      wr(8'h00, 32'h0);
      wr(8'h30, 32'h0);
      wr(8'h08, 32'(m));
      wr(8'h00, 32'h1);
      repeat (d) @(posedge clk_i);
      wr(8'h00, 32'h0);
      bus(8'h30, 1'b0, 32'h0);
      if (m == 0) c1 = rd;
    end
    chk("single upper", {16'h0, c1[31:16]}, 32'h0);
    chk("mirror count", rd, c1 * TER_INC_MIRROR);
    $display("increment test done");
    for (int e = 0; e < 4; e++) begin
      wr(8'h08, {24'h0, 1'($urandom), 7'h0});
      wr(8'h00, {24'h0, 2'(e), 6'h0});
      wr(8'h0C, 32'h3);
      pin <= 1'b1;
      repeat (6) @(posedge clk_i);
      rdc(8'h0C, "rise flag", {31'h0, e[0]});
      wr(8'h0C, 32'h3);
      pin <= 1'b0;
      repeat (6) @(posedge clk_i);
      rdc(8'h0C, "fall flag", {31'h0, e[1]});
      rdc(8'h20, "capture", (e == 0) ? 32'h0 : c1 * TER_INC_MIRROR);
    end
    wr(8'h08, 32'h1);
    for (int k = 0; k < 2; k++) begin
      run_match(k ? 32'h0005_0005 : 32'h0000_0005, 8'h00);
      rdc(8'h0C, "match flag", k ? 32'h3 : 32'h1);
    end
    $display("event test done");
    for (int i = 0; i < 32; i++) begin
      if (i == 16) wr(8'h0C, 32'h2);
      c1 = $urandom;
      wr(8'h40, {30'h0, c1[1:0]});
      wr(8'h00, {24'h0, 2'(i), 1'b0, i[2], 4'h0});
      wr(8'h08, {24'h0, i[3], 7'h0});
      @(posedge clk_i);
      chk("route", {30'h0, dma_req, irq}, {30'h0, route(i[4] ? 2'h1 : 2'h3, 2'(i), i[2], i[3], c1[1:0])});
    end
    wr(8'h40, 32'h3);
    $display("routing test done");
    wr(8'h0C, 32'h2);
    rdc(8'h0C, "keep zero", 32'h1);
    wr(8'h08, 32'h1);
    run_match(32'h0005_0005, 8'hC0);
    wr(8'h0C, 32'h0);
    rdc(8'h0C, "write zero", 32'h3);
    chk("irq while set", {31'h0, irq}, 32'h1);
    wr(8'h0C, 32'h3);
    rdc(8'h0C, "both clear", 32'h0);
    chk("irq negated", {31'h0, irq}, 32'h0);
    wr(8'h08, 32'h81);
    run_match(32'h0005_0005, 8'h10);
    chk("req held", {31'h0, dma_req}, 32'h1);
    lat <= 3'($urandom);
    ack_en <= 1'b1;
    d = 0;
    while (dma_req !== 1'b0 && d < 30) begin
      @(posedge clk_i);
      d++;
    end
    ack_en <= 1'b0;
    rdc(8'h0C, "ack clear", 32'h0);
    chk("req dropped", {31'h0, dma_req}, 32'h0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h08, "ext after reset", 32'h0);
    rdc(8'h40, "mask after reset", {30'h0, TER_MASK_RST});
    $display("clear test done");
    tally_and_finish();
  end
endmodule // tb
